// File: src/msp_serial_port.sv
`timescale 1ns/1ns
`include "msp_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] chip-select resets inactive-low, software may invert
// [R2] master applies polarities only on first enable or on leaving forced single mode
// [R3] inactive-high then enable gives rising chip-select
// [R4] slave loads on chip-select edge, else underflow
// [R5] master software: single, configure, force, unsingle
// [R6] leaving single mode with force applies polarity
// [R7] slave software configures then enables channel zero
// [R8] master channel enabled only after slave channel
// [R9] only our own slave logic misreads edge
// [R10] forced chip-select holds line, no transfer
module msp_serial_port
   import msp_pkg::*;
#(
   parameter int NCH  = `MSP_NCH_DEFAULT,
   parameter int WORD = `MSP_WORD_DEFAULT,
   parameter int DIV  = `MSP_DIV_DEFAULT
)
(
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_i,
   // configuration and channel enables
   input  wire msp_pkg::msp_cfg_type  cfg_i,
   input  wire logic [NCH-1:0]        ch_en_i,
   // transfer data
   input  wire logic                  start_i,
   input  wire logic [WORD-1:0]       tx_data_i,
   input  wire logic                  tx_valid_i,
   output logic                       tx_taken_o,
   output logic [WORD-1:0]            rx_data_o,
   output logic                       done_o,
   output msp_pkg::msp_status_type    status_o,
   // serial clock pin
   input  wire logic                  sclk_i,
   output logic                       sclk_o,
   output logic                       sclk_oe_o,
   // chip-select pin
   input  wire logic                  cs_i,
   output logic                       cs_o,
   output logic                       cs_oe_o,
   // data pins
   input  wire logic                  sdi_i,
   output logic                       sdo_o,
   output logic                       sdo_oe_o
);

   localparam int CW = $clog2(WORD + 1);
   localparam int DW = $clog2(DIV + 1);

   logic [2:0]      pins_s;
   logic            cs_s;
   logic            sclk_s;
   logic            sdi_s;
   logic            cs_prev_reg;
   logic            sclk_prev_reg;
   logic            en_prev_reg;
   logic            single_prev_reg;
   logic            cs_high_reg;
   logic            clk_high_reg;
   logic            busy_reg;
   logic            phase_reg;
   logic [DW-1:0]   div_reg;
   logic [CW-1:0]   cnt_reg;
   logic [WORD-1:0] tx_sh_reg;
   logic [WORD-1:0] rx_sh_reg;
   logic            any_en;
   logic            apply;
   logic            forced;
   logic            tick;
   logic            m_start;
   logic            slave_en;
   logic            cs_act;
   logic            cs_edge;
   logic            sclk_edge;
   logic            lead_evt;
   logic            trail_evt;
   logic            load_evt;
   logic            underflow_reg;
   logic [`MSP_WARM_LEN-1:0] warm_reg;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   msp_sync
   #(
      .WIDTH (`MSP_SYNC_WIDTH)
   )
   u_sync
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   ({cs_i, sclk_i, sdi_i}),
      .sync_o    (pins_s)
   );

   assign cs_s   = pins_s[2];
   assign sclk_s = pins_s[1];
   assign sdi_s  = pins_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // edge history of enables, mode bit and synchronised chip-select and clock pins
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         en_prev_reg     <= 1'b0;
         single_prev_reg <= 1'b0;
         cs_prev_reg     <= `MSP_CS_IDLE_RST;
         sclk_prev_reg   <= `MSP_CLK_IDLE_RST;
      end
      else
      begin
         en_prev_reg     <= any_en;
         single_prev_reg <= cfg_i.single;
         cs_prev_reg     <= cs_s;
         sclk_prev_reg   <= sclk_s;
      end
   end

   // warm-up: reset values of the pin history are not real line edges
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         warm_reg <= '0;
      else
         warm_reg <= {warm_reg[`MSP_WARM_LEN-2:0], 1'b1};
   end

   // polarity takes effect on first enable or on leaving forced single mode
   assign any_en = |ch_en_i;
   assign apply  = cfg_i.master &&
                   ((any_en && !en_prev_reg) ||                          // [R2]
                    (single_prev_reg && !cfg_i.single && cfg_i.force_cs)); // [R6]

   ////////////////////////////////////////////////////////////////////////////
   // applied bus polarity, not the written configuration
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cs_high_reg  <= `MSP_CS_IDLE_RST;  // [R1]
         clk_high_reg <= `MSP_CLK_IDLE_RST;
      end
      else if (apply)
      begin
         cs_high_reg  <= cfg_i.cs_idle_high; // [R3]
         clk_high_reg <= cfg_i.clk_idle_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master: forced chip-select blocks transfers, divider paces the clock
   assign forced  = cfg_i.single && cfg_i.force_cs;
   assign m_start = cfg_i.master && start_i && any_en && !forced && !busy_reg; // [R10]
   assign tick    = busy_reg && (div_reg == DW'(DIV - 1));

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         div_reg <= '0;
      else if (!busy_reg || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 1'b1;
   end

   // busy and clock phase of the master
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         busy_reg  <= 1'b0;
         phase_reg <= 1'b0;
      end
      else if (m_start)
      begin
         busy_reg  <= 1'b1;
         phase_reg <= 1'b0;
      end
      else if (tick)
      begin
         phase_reg <= !phase_reg;
         if (phase_reg && cnt_reg == CW'(WORD - 1))
            busy_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave: any chip-select transition is taken as a transfer start
   assign slave_en  = !cfg_i.master && ch_en_i[`MSP_SLAVE_CH];
   assign cs_act    = (cs_s != cfg_i.cs_idle_high);
   assign cs_edge   = slave_en && warm_reg[`MSP_WARM_LEN-1] &&
                      (cs_s != cs_prev_reg);  // [R4] [R9]
   assign sclk_edge = slave_en && cs_act && (sclk_s != sclk_prev_reg);

   // shared shift events for both roles
   assign lead_evt  = cfg_i.master ? (tick && !phase_reg)
                                   : (sclk_edge && sclk_s != cfg_i.clk_idle_high);
   assign trail_evt = cfg_i.master ? (tick && phase_reg)
                                   : (sclk_edge && sclk_s == cfg_i.clk_idle_high);
   assign load_evt  = m_start || (cs_edge && tx_valid_i); // [R4]
   assign tx_taken_o = load_evt;

   // underflow pulse when the slave finds nothing to load
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         underflow_reg <= 1'b0;
      else
         underflow_reg <= cs_edge && !tx_valid_i; // [R4]
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift registers and bit counter
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tx_sh_reg <= '0;
         rx_sh_reg <= '0;
         cnt_reg   <= '0;
      end
      else if (load_evt)
      begin
         tx_sh_reg <= tx_data_i;
         cnt_reg   <= '0;
      end
      else
      begin
         if (lead_evt)
            rx_sh_reg <= {rx_sh_reg[WORD-2:0], sdi_s};
         if (trail_evt)
         begin
            tx_sh_reg <= {tx_sh_reg[WORD-2:0], 1'b0};
            cnt_reg   <= (cnt_reg == CW'(WORD - 1)) ? '0 : cnt_reg + 1'b1;
         end
      end
   end

   // received word and completion pulse
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_data_o <= '0;
         done_o    <= 1'b0;
      end
      else
      begin
         done_o <= trail_evt && cnt_reg == CW'(WORD - 1);
         if (trail_evt && cnt_reg == CW'(WORD - 1))
            rx_data_o <= rx_sh_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive: master owns clock and select, data follows the role
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sclk_o    <= `MSP_CLK_IDLE_RST;
         cs_o      <= `MSP_CS_IDLE_RST;   // [R1]
         sclk_oe_o <= 1'b0;
         cs_oe_o   <= 1'b0;
         sdo_oe_o  <= 1'b0;
      end
      else
      begin
         sclk_o    <= clk_high_reg ^ (busy_reg && phase_reg);
         cs_o      <= (busy_reg || (cfg_i.master && forced)) ? !cs_high_reg
                                                             : cs_high_reg; // [R10]
         sclk_oe_o <= cfg_i.master;
         cs_oe_o   <= cfg_i.master;
         sdo_oe_o  <= cfg_i.master ? busy_reg : (slave_en && cs_act);
      end
   end

   assign sdo_o = tx_sh_reg[WORD-1];

   // status reflects applied polarity
   assign status_o = {underflow_reg, busy_reg, cs_high_reg, clk_high_reg};

endmodule

// File: src/msp_defs.svh
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// chip-select idle level after reset: inactive low
`define MSP_CS_IDLE_RST    1'b0
// serial clock idle level after reset
`define MSP_CLK_IDLE_RST   1'b0
// system clock cycles per serial half period
`define MSP_DIV_DEFAULT    4
// bits in one serial word
`define MSP_WORD_DEFAULT   8
// number of channels
`define MSP_NCH_DEFAULT    4
// channel used when the port acts as slave
`define MSP_SLAVE_CH       0
// width of the pin synchroniser, one bit per pin
`define MSP_SYNC_WIDTH     3
// cycles after reset before synchronised pin history is trusted
`define MSP_WARM_LEN       3

`endif

// File: src/msp_pkg.sv
package msp_pkg;

   // configuration bits steering the port
   typedef struct packed {
      logic master;         // 1: master, 0: slave
      logic cs_idle_high;   // chip-select inactive level is high
      logic clk_idle_high;  // serial clock idle level is high
      logic single;         // single-channel mode
      logic force_cs;       // forced chip-select
   } msp_cfg_type;

   // state reported back to the user
   typedef struct packed {
      logic underflow;      // slave load found no transmit data
      logic busy;           // master transfer running
      logic cs_idle_high;   // polarity now applied on the bus
      logic clk_idle_high;
   } msp_status_type;

endpackage

// File: src/msp_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for pins arriving from outside the clock domain
module msp_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   // asynchronous inputs and synchronised copies
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_reg <= '0;
         sync_o   <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule

// File: verif/msp_far_master.sv
`timescale 1ns/1ns
// far master: one frame of eight bits per rising go_i, 400 ns link clock
module msp_far_master
(
   // frame request and polarity
   input  wire logic       go_i,
   input  wire logic       idle_i,
   input  wire logic [7:0] data_i,
   // bus lines
   output logic            cs_o,
   output logic            sclk_o,
   output logic            sdo_o
);
   logic sel = 1'h0;
   // chip-select sits at the idle level outside frames
   assign cs_o = sel ^ idle_i;
   initial sclk_o = 1'h0;
   initial sdo_o = 1'h0;
   // frame: clock runs only while selected, msb first
   always @(posedge go_i)
   begin
      #7 sel = 1'h1;
      for (int i = 7; i >= 0; i--)
      begin
         sdo_o = data_i[i];
         #200 sclk_o = 1'h1;
         #200 sclk_o = 1'h0;
      end
      #200 sel = 1'h0;
      sdo_o = ~sdo_o; // released line shows no stale bit
   end
endmodule

// File: verif/msp_serial_port_chk.sv
`timescale 1ns/1ns
module msp_serial_port_chk
   import msp_pkg::*;
#(
   parameter int NCH = 4
)
(
   // clock and reset
   input wire logic                  sys_clk_i,
   input wire logic                  reset_i,
   // watched ports
   input wire msp_pkg::msp_cfg_type    cfg_i,
   input wire logic [NCH-1:0]          ch_en_i,
   input wire logic                    start_i,
   input wire logic                    tx_valid_i,
   input wire logic                    tx_taken_o,
   input wire msp_pkg::msp_status_type status_o,
   input wire logic                    cs_i,
   input wire logic                    cs_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // forced chip-select held three cycles
   sequence s_forced;
      (cfg_i.master && cfg_i.single && cfg_i.force_cs)[*3];
   endsequence
   // slave sees a chip-select change with nothing to send
   sequence s_dry_edge;
      !cfg_i.master && ch_en_i[0] && !tx_valid_i && $changed(cs_i);
   endsequence
   AST_FIRST_EN: assert property (cfg_i.master && |ch_en_i && !$past(|ch_en_i)
      |=> status_o.cs_idle_high == $past(cfg_i.cs_idle_high)) else $error("no apply");
   AST_UNSINGLE: assert property (cfg_i.master && $fell(cfg_i.single) && cfg_i.force_cs
      |=> status_o.cs_idle_high == $past(cfg_i.cs_idle_high)) else $error("no update");
   AST_IDLE_CS: assert property (cfg_i.master && !cfg_i.single && !status_o.busy
      && !$past(status_o.busy) && !$past(cfg_i.single)
      |-> cs_o == $past(status_o.cs_idle_high)) else $error("cs idle");
   AST_FORCE_HOLD: assert property (s_forced |-> cs_o != status_o.cs_idle_high)
      else $error("forced cs level");
   AST_FORCE_NOXFER: assert property (s_forced ##0 start_i |-> !tx_taken_o)
      else $error("forced start taken");
   AST_UF_CAUSE: assert property (status_o.underflow |-> !cfg_i.master && !$past(tx_valid_i))
      else $error("bad underflow");
   AST_LOAD_VALID: assert property (!cfg_i.master && tx_taken_o |-> tx_valid_i)
      else $error("load without data");
   AST_UF_RAISE: assert property (s_dry_edge |-> ##[2:6] status_o.underflow)
      else $error("underflow missing");
   AST_UF_DISABLED: assert property ((!ch_en_i[0])[*6] |-> !status_o.underflow)
      else $error("underflow while off");
endmodule
bind msp_serial_port msp_serial_port_chk #(.NCH(NCH)) i_msp_serial_port_chk (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .cfg_i(cfg_i), .ch_en_i(ch_en_i), .start_i(start_i),
   .tx_valid_i(tx_valid_i), .tx_taken_o(tx_taken_o), .status_o(status_o), .cs_i(cs_i),
   .cs_o(cs_o));

// File: verif/msp_serial_port_tb.sv
`timescale 1ns/1ns
module msp_serial_port_tb;
   import msp_pkg::*;
   logic           sys_clk_i = 1'h0;
   logic           reset_i = 1'h1;
   logic           start_i = 1'h0;
   logic           tx_valid_i = 1'h0;
   logic           go = 1'h0;
   logic [3:0]     ch_en = 4'h0;
   msp_cfg_type    cfg = 5'h00;
   msp_status_type st;
   logic           tx_taken, cs, cs_p, sclk_p, sdo_p, dn;
   logic [7:0]     rx;
   int             num_errors = 0, tests_run = 0, cyc = 0, n_uf = 0, n_tk = 0, n_dn = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   msp_serial_port #(.DIV(2)) i_msp_serial_port (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .cfg_i(cfg), .ch_en_i(ch_en), .start_i(start_i), .tx_data_i(8'h5a),
      .tx_valid_i(tx_valid_i), .tx_taken_o(tx_taken), .rx_data_o(rx), .done_o(dn),
      .status_o(st), .sclk_i(sclk_p), .sclk_o(), .sclk_oe_o(), .cs_i(cs_p), .cs_o(cs),
      .cs_oe_o(), .sdi_i(sdo_p), .sdo_o(), .sdo_oe_o());
   msp_far_master i_msp_far_master (.go_i(go), .idle_i(cfg.cs_idle_high), .data_i(8'h5a),
      .cs_o(cs_p), .sclk_o(sclk_p), .sdo_o(sdo_p));
   // event counters and hang limit
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (st.underflow === 1'h1) n_uf++;
      if (tx_taken === 1'h1) n_tk++;
      if (dn === 1'h1) n_dn++;
      if (cyc == 5000)
      begin
         num_errors++;
         finish_test();
      end
   end
   task chk(input logic e, input logic a);
      tests_run++;
      if (a !== e)
      begin
         num_errors++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask
   task chk_w(input logic [7:0] e, input logic [7:0] a);
      tests_run++;
      if (a !== e)
      begin
         num_errors++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task rst(input msp_cfg_type c);
      @(posedge sys_clk_i);
      reset_i <= 1'h1;
      cfg <= c;
      ch_en <= 4'h0;
      tk(4);
      reset_i <= 1'h0;
      tk(1);
   endtask
   task frame(input logic v, input logic en, input int uf, input int tn, input int dn_n);
      @(posedge sys_clk_i);
      tx_valid_i <= v;
      ch_en <= {3'h0, en};
      tk(8);
      n_uf = 0;
      n_tk = 0;
      n_dn = 0;
      @(posedge sys_clk_i);
      go <= 1'h1;
      tk(90);
      go <= 1'h0;
      chk(1'h1, n_uf == uf);
      chk(1'h1, n_tk == tn);
      chk(1'h1, n_dn == dn_n);
      if (en) chk_w(8'h5a, rx);
   endtask
   ///////////////////////////////////////////////////////////////////////////////////////////
   task t_master;
      rst(5'h18);
      chk(1'h0, cs);
      chk(1'h0, st.cs_idle_high);
      tk(5);
      chk(1'h0, cs);
      cfg.single <= 1'h1;
      tk(1);
      cfg.force_cs <= 1'h1;
      tk(4);
      chk(1'h1, cs);
      n_tk = 0;
      start_i <= 1'h1;
      tk(1);
      start_i <= 1'h0;
      tk(2);
      chk(1'h0, st.busy);
      chk(1'h1, n_tk == 0);
      cfg.single <= 1'h0;
      tk(3);
      chk(1'h1, st.cs_idle_high);
      chk(1'h1, cs);
      cfg.force_cs <= 1'h0;
      ch_en <= 4'h1;
      tk(4);
      chk(1'h1, cs);
      n_dn = 0;
      start_i <= 1'h1;
      tk(1);
      start_i <= 1'h0;
      chk(1'h1, st.busy);
      tk(2);
      chk(1'h0, cs);
      tk(40);
      chk(1'h1, n_dn == 1);
      chk(1'h0, st.busy);
      chk_w(8'h00, rx);
   endtask
   task t_enable;
      rst(5'h18);
      ch_en <= 4'h2;
      tk(1);
      chk(1'h0, cs);
      tk(3);
      chk(1'h1, cs);
   endtask
   task t_slave;
      rst(5'h08);
      frame(1'h0, 1'h1, 2, 0, 1);
      frame(1'h1, 1'h1, 0, 2, 1);
      frame(1'h0, 1'h0, 0, 0, 0);
   endtask
   task finish_test;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      t_master();
      t_enable();
      t_slave();
      finish_test();
   end
endmodule
